// ### hdl/slc_pkg.sv
/*
  Constants, register map and carrier types of the lane control and status block.
  Assumes a single 125 MHz clock and an APB master for software access.
*/
// Functional notes
// RULE_01 - rx pcs reset waits for rx user ready
// RULE_02 - rx pma reset pulse starts pma sequence
// RULE_03 - pma done low during full/pma reset
// RULE_04 - counter clear input zeroes error counter
// RULE_05 - prbs error output is live, not sticky
// RULE_06 - rx checker select: off, 7, 15, 23, 31
// RULE_07 - no checking for non-prbs select values
// RULE_08 - expected bit derived from received history
// RULE_09 - rx done low in reset, needs ready
// RULE_10 - buffer error bit sticky until buffer reset
// RULE_11 - buffer half-full bit follows fifo level
// RULE_12 - inhibit forces positive 0, negative 1
// RULE_13 - tx pcs reset leaves tx pma alone
// RULE_14 - tx pma reset resets pma and pcs
// RULE_15 - polarity 1 swaps serial outputs
// RULE_16 - force error corrupts prbs, not data
// RULE_17 - main tap input used only when enabled
// RULE_18 - tx pattern select: off, 7, 15, 23, 31
// RULE_19 - asynchronous inputs pass two flip-flops first
package slc_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 8000;
  localparam int unsigned RST_SEQ_TIME_NS = 200;
  localparam int unsigned RST_SEQ_CYCLES  =
    (RST_SEQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_ERR_CNT    = 8'h08;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_EVT_CLEAR  = 8'h10;
  localparam logic [7:0] ADDR_EVT_ENABLE = 8'h14;

  localparam logic [2:0] PAT_OFF    = 3'h0;
  localparam logic [2:0] PAT_PRBS7  = 3'h1;
  localparam logic [2:0] PAT_PRBS15 = 3'h2;
  localparam logic [2:0] PAT_PRBS23 = 3'h3;
  localparam logic [2:0] PAT_PRBS31 = 3'h4;

  // control register, bit 0 is tx_inhibit
  typedef struct packed {
    logic       main_tap_direct_enable;
    logic       rx_err_cnt_clear;
    logic [2:0] rx_check_sel;
    logic       tx_force_err;
    logic [2:0] tx_pattern_sel;
    logic       tx_polarity;
    logic       tx_inhibit;
  } slc_ctrl_s;
  localparam int        CTRL_W     = 11;
  localparam slc_ctrl_s CTRL_RESET = 11'h000;

  // live status register bit positions
  localparam int ST_RX_PMA_DONE = 0;
  localparam int ST_RX_DONE     = 1;
  localparam int ST_TX_DONE     = 2;
  localparam int ST_TX_HALF     = 3;
  localparam int ST_TX_BUF_ERR  = 4;
  localparam int ST_RX_PRBS_ERR = 5;

  // event bits, same layout in status, clear and enable
  localparam int EV_RX_DONE  = 0;
  localparam int EV_TX_DONE  = 1;
  localparam int EV_BUF_ERR  = 2;
  localparam int EV_PRBS_ERR = 3;
  localparam int EVT_W       = 4;
  localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

  localparam logic [30:0] PRBS_SEED = 31'h7FFFFFFF;
endpackage : slc_pkg

// ### hdl/slc_lane_ctrl.sv
/*
  Per-lane transceiver control and status: reset sequencing, tx fifo and
  serialiser, prbs generator and checker, polarity, inhibit, event interrupt.
  Assumes everything runs on pclk; reset pins, rx serial pin and tap pins are
  asynchronous and synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module slc_lane_ctrl #(
  parameter int WORD_W     = 8,
  parameter int FIFO_DEPTH = 8,
  parameter int ERR_CNT_W  = 16,
  parameter int TAP_W      = 5,
  parameter logic [4:0] MAIN_TAP_DEFAULT = 5'h00
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // asynchronous pins
  input  wire logic              rx_full_reset,
  input  wire logic              rx_pma_reset,
  input  wire logic              rx_pcs_reset,
  input  wire logic              rx_user_ready,
  input  wire logic              tx_pma_reset,
  input  wire logic              tx_pcs_reset,
  input  wire logic              rx_serial_in,
  input  wire logic [TAP_W-1:0]  main_tap_coef,
  // tx user data
  input  wire logic [WORD_W-1:0] tx_parallel_word,
  input  wire logic              tx_word_valid,
  output logic                   tx_word_ready,
  // serial and status outputs
  output logic                   serial_out_pos,
  output logic                   serial_out_neg,
  output logic                   rx_pma_reset_done,
  output logic                   rx_reset_done,
  output logic                   tx_reset_done,
  output logic                   rx_prbs_err,
  output logic [1:0]             tx_buf_status,
  output logic [TAP_W-1:0]       main_tap_applied,
  output logic                   irq
);
  localparam int AW     = $clog2(FIFO_DEPTH);
  localparam int SEQ_W  = $clog2(slc_pkg::RST_SEQ_CYCLES + 1);
  localparam int BIT_W  = $clog2(WORD_W);
  localparam int SYNC_W = 7 + TAP_W;
  localparam logic [SEQ_W-1:0] SEQ_LOAD = SEQ_W'(slc_pkg::RST_SEQ_CYCLES);
  localparam logic [AW:0]      HALF     = (AW + 1)'(FIFO_DEPTH / 2);
  localparam int SEQ_BOUND = slc_pkg::RST_SEQ_CYCLES + 4;

  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 || WORD_W < 2 || TAP_W != 5)
    $error("slc_lane_ctrl: unsupported parameter values");

  function automatic logic is_prbs(input logic [2:0] sel);
    is_prbs = (sel >= slc_pkg::PAT_PRBS7) && (sel <= slc_pkg::PAT_PRBS31);
  endfunction : is_prbs

  function automatic logic prbs_fb(input logic [30:0] s, input logic [2:0] sel);
    case (sel)
      slc_pkg::PAT_PRBS7:  prbs_fb = s[6] ^ s[5];
      slc_pkg::PAT_PRBS15: prbs_fb = s[14] ^ s[13];
      slc_pkg::PAT_PRBS23: prbs_fb = s[22] ^ s[17];
      slc_pkg::PAT_PRBS31: prbs_fb = s[30] ^ s[27];
      default:             prbs_fb = 1'b0;
    endcase
  endfunction : prbs_fb

  // pin synchronisers
  logic [SYNC_W-1:0] sync1_q, sync2_q;
  always_ff @(posedge pclk or negedge presetn) begin // [RULE_19]
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {main_tap_coef, rx_serial_in, tx_pcs_reset, tx_pma_reset,
                  rx_user_ready, rx_pcs_reset, rx_pma_reset, rx_full_reset};
      sync2_q <= sync1_q;
    end
  end
  logic rx_full_s, rx_pma_s, rx_pcs_s, rx_ready_s, tx_pma_s, tx_pcs_s, rx_bit_s;
  logic [TAP_W-1:0] tap_s;
  assign {tap_s, rx_bit_s, tx_pcs_s, tx_pma_s, rx_ready_s, rx_pcs_s, rx_pma_s, rx_full_s}
    = sync2_q;

  // apb registers
  localparam int EVT_W_L  = slc_pkg::EVT_W;
  localparam int CTRL_W_L = slc_pkg::CTRL_W;
  slc_pkg::slc_ctrl_s ctrl_q;
  logic [EVT_W_L-1:0] evt_q, evt_en_q;
  logic acc, setup_phase;
  assign setup_phase = psel && penable && !pready;
  assign acc         = psel && penable && pready;

  logic [ERR_CNT_W-1:0] err_cnt_q;
  logic [5:0]           status;
  logic [31:0]          rd_val;
  logic                 addr_ok;
  always_comb begin
    addr_ok = 1'b1;
    rd_val  = 32'h00000000;
    case (paddr)
      slc_pkg::ADDR_CTRL:       rd_val = 32'(ctrl_q);
      slc_pkg::ADDR_STATUS:     rd_val = 32'(status);
      slc_pkg::ADDR_ERR_CNT:    rd_val = 32'(err_cnt_q);
      slc_pkg::ADDR_EVT_STATUS: rd_val = 32'(evt_q);
      slc_pkg::ADDR_EVT_CLEAR:  rd_val = 32'h00000000;
      slc_pkg::ADDR_EVT_ENABLE: rd_val = 32'(evt_en_q);
      default:                  addr_ok = 1'b0;
    endcase
  end

  // one wait state: answer registered during the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !addr_ok;
      prdata  <= (setup_phase && !pwrite) ? rd_val : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= slc_pkg::CTRL_RESET;
      evt_en_q <= slc_pkg::EVT_RESET;
    end else if (acc && pwrite) begin
      if (paddr == slc_pkg::ADDR_CTRL) ctrl_q <= slc_pkg::slc_ctrl_s'(pwdata[CTRL_W_L-1:0]);
      if (paddr == slc_pkg::ADDR_EVT_ENABLE) evt_en_q <= pwdata[EVT_W_L-1:0];
    end
  end

  // rx reset sequencing
  logic [SEQ_W-1:0] rx_pma_cnt_q, rx_pcs_cnt_q;
  logic             rx_pcs_pend_q, rx_pcs_prev_q, rx_full_prev_q;
  logic             rx_pcs_start;
  assign rx_pcs_start = rx_pcs_pend_q && !rx_pcs_s && !rx_full_s && rx_ready_s
                        && rx_pma_cnt_q == '0; // [RULE_01]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pma_cnt_q <= SEQ_LOAD;
    end else if (rx_full_s || rx_pma_s) begin // [RULE_02]
      rx_pma_cnt_q <= SEQ_LOAD;
    end else if (rx_pma_cnt_q != '0) begin
      rx_pma_cnt_q <= rx_pma_cnt_q - SEQ_W'(1);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pcs_prev_q  <= 1'b0;
      rx_full_prev_q <= 1'b0;
      rx_pcs_pend_q  <= 1'b1;
      rx_pcs_cnt_q   <= '0;
    end else begin
      rx_pcs_prev_q  <= rx_pcs_s;
      rx_full_prev_q <= rx_full_s;
      if (rx_pcs_start) begin
        rx_pcs_pend_q <= 1'b0;
        rx_pcs_cnt_q  <= SEQ_LOAD;
      end else begin
        if ((rx_pcs_prev_q && !rx_pcs_s) || (rx_full_prev_q && !rx_full_s))
          rx_pcs_pend_q <= 1'b1;
        if (rx_pcs_cnt_q != '0) rx_pcs_cnt_q <= rx_pcs_cnt_q - SEQ_W'(1);
      end
    end
  end
  logic rx_done_d;
  assign rx_done_d = !rx_full_s && !rx_pcs_s && !rx_pcs_pend_q && rx_pcs_cnt_q == '0
                     && rx_pma_cnt_q == '0 && rx_ready_s; // [RULE_09]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pma_reset_done <= 1'b0;
      rx_reset_done     <= 1'b0;
    end else begin
      rx_pma_reset_done <= !rx_full_s && !rx_pma_s && rx_pma_cnt_q == '0; // [RULE_03]
      rx_reset_done     <= rx_done_d;
    end
  end

  // tx reset sequencing
  logic [SEQ_W-1:0] tx_pma_cnt_q, tx_pcs_cnt_q;
  logic             tx_pma_busy, tx_pcs_busy;
  assign tx_pma_busy = tx_pma_cnt_q != '0;
  assign tx_pcs_busy = tx_pcs_cnt_q != '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pma_cnt_q <= SEQ_LOAD;
      tx_pcs_cnt_q <= SEQ_LOAD;
    end else begin
      if (tx_pma_s) tx_pma_cnt_q <= SEQ_LOAD; // [RULE_14]
      else if (tx_pma_busy) tx_pma_cnt_q <= tx_pma_cnt_q - SEQ_W'(1);
      // pcs alone never touches the pma counter
      if (tx_pma_s || tx_pcs_s) tx_pcs_cnt_q <= SEQ_LOAD; // [RULE_13] [RULE_14]
      else if (tx_pcs_busy) tx_pcs_cnt_q <= tx_pcs_cnt_q - SEQ_W'(1);
    end
  end

  // tx fifo, cleared while the tx pcs is in reset
  logic [WORD_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [AW:0]       wr_ptr_q, rd_ptr_q, fill;
  logic              push, pop, full, empty, overflow, underflow;
  assign fill     = wr_ptr_q - rd_ptr_q;
  assign full     = fill == (AW + 1)'(FIFO_DEPTH);
  assign empty    = fill == '0;
  assign push     = tx_word_valid && !full && !tx_pcs_busy;
  assign overflow = tx_word_valid && full && !tx_pcs_busy;
  always_ff @(posedge pclk) begin
    if (push) fifo_mem[wr_ptr_q[AW-1:0]] <= tx_parallel_word;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q      <= '0;
      rd_ptr_q      <= '0;
      tx_word_ready <= 1'b0;
    end else if (tx_pcs_busy) begin
      wr_ptr_q      <= '0;
      rd_ptr_q      <= '0;
      tx_word_ready <= 1'b0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + (AW + 1)'(1);
      if (pop)  rd_ptr_q <= rd_ptr_q + (AW + 1)'(1);
      tx_word_ready <= (wr_ptr_q + (AW + 1)'(push) - rd_ptr_q - (AW + 1)'(pop))
                       != (AW + 1)'(FIFO_DEPTH);
    end
  end

  // serialiser and prbs generator
  logic [WORD_W-1:0] shift_q;
  logic [BIT_W-1:0]  bit_cnt_q;
  logic [30:0]       gen_q;
  logic [2:0]        tx_sel_prev_q;
  logic              gen_on, word_edge, gen_fb, tx_bit;
  assign gen_on    = is_prbs(ctrl_q.tx_pattern_sel); // [RULE_18]
  assign word_edge = bit_cnt_q == '0;
  assign pop       = word_edge && !gen_on && !empty && !tx_pcs_busy;
  assign underflow = word_edge && !gen_on && empty && !tx_pcs_busy;
  assign gen_fb    = prbs_fb(gen_q, ctrl_q.tx_pattern_sel);
  // injected errors only exist in the generated stream
  assign tx_bit    = gen_on ? (gen_fb ^ ctrl_q.tx_force_err) : shift_q[0]; // [RULE_16]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q       <= '0;
      bit_cnt_q     <= '0;
      gen_q         <= slc_pkg::PRBS_SEED;
      tx_sel_prev_q <= slc_pkg::PAT_OFF;
    end else if (tx_pcs_busy) begin
      shift_q   <= '0;
      bit_cnt_q <= '0;
      gen_q     <= slc_pkg::PRBS_SEED;
    end else begin
      tx_sel_prev_q <= ctrl_q.tx_pattern_sel;
      // reseed on a pattern change so a short window never sits at all zeros
      if (ctrl_q.tx_pattern_sel != tx_sel_prev_q) gen_q <= slc_pkg::PRBS_SEED;
      else if (gen_on) gen_q <= {gen_q[29:0], gen_fb};
      bit_cnt_q <= (bit_cnt_q == BIT_W'(WORD_W - 1)) ? '0 : bit_cnt_q + BIT_W'(1);
      if (pop) shift_q <= fifo_mem[rd_ptr_q[AW-1:0]];
      else if (word_edge) shift_q <= '0;
      else shift_q <= shift_q >> 1;
    end
  end
  // pop loads the word at the edge; its first bit leaves on the next cycle

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pos <= 1'b0;
      serial_out_neg <= 1'b1;
    end else if (tx_pma_busy || ctrl_q.tx_inhibit) begin // [RULE_12]
      serial_out_pos <= 1'b0;
      serial_out_neg <= 1'b1;
    end else begin
      serial_out_pos <= tx_bit ^ ctrl_q.tx_polarity; // [RULE_15]
      serial_out_neg <= ~(tx_bit ^ ctrl_q.tx_polarity);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_status <= 2'h0;
      tx_reset_done <= 1'b0;
    end else begin
      if (tx_pcs_busy) tx_buf_status[1] <= 1'b0;
      else if (overflow || underflow) tx_buf_status[1] <= 1'b1; // [RULE_10]
      tx_buf_status[0] <= !tx_pcs_busy && fill >= HALF; // [RULE_11]
      tx_reset_done    <= !tx_pma_busy && !tx_pcs_busy;
    end
  end

  // rx prbs checker: self-synchronising on received history
  logic [30:0] hist_q;
  logic [4:0]  rx_fill_q;
  logic [2:0]  rx_sel_prev_q;
  logic        check_en;
  assign check_en = is_prbs(ctrl_q.rx_check_sel) && rx_fill_q == 5'h1F; // [RULE_06] [RULE_07]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_q        <= '0;
      rx_fill_q     <= '0;
      rx_sel_prev_q <= slc_pkg::PAT_OFF;
      rx_prbs_err   <= 1'b0;
    end else begin
      hist_q        <= {hist_q[29:0], rx_bit_s}; // [RULE_08]
      rx_sel_prev_q <= ctrl_q.rx_check_sel;
      if (ctrl_q.rx_check_sel != rx_sel_prev_q) rx_fill_q <= '0;
      else if (rx_fill_q != 5'h1F) rx_fill_q <= rx_fill_q + 5'h01;
      rx_prbs_err <= check_en && (rx_bit_s != prbs_fb(hist_q, ctrl_q.rx_check_sel)); // [RULE_05]
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) err_cnt_q <= '0;
    else if (ctrl_q.rx_err_cnt_clear) err_cnt_q <= '0; // [RULE_04]
    else if (rx_prbs_err && err_cnt_q != '1) err_cnt_q <= err_cnt_q + ERR_CNT_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) main_tap_applied <= MAIN_TAP_DEFAULT;
    else main_tap_applied <= ctrl_q.main_tap_direct_enable ? tap_s : MAIN_TAP_DEFAULT; // [RULE_17]
  end

  // events and interrupt; a new event wins over a clear in the same cycle
  logic [EVT_W_L-1:0] ev, clr, evt_d;
  assign status = {rx_prbs_err, tx_buf_status[1], tx_buf_status[0],
                   tx_reset_done, rx_reset_done, rx_pma_reset_done};
  always_comb begin
    ev = '0;
    ev[slc_pkg::EV_RX_DONE]  = rx_done_d && !rx_reset_done;
    ev[slc_pkg::EV_TX_DONE]  = !tx_pma_busy && !tx_pcs_busy && !tx_reset_done;
    ev[slc_pkg::EV_BUF_ERR]  = (overflow || underflow) && !tx_buf_status[1];
    ev[slc_pkg::EV_PRBS_ERR] = rx_prbs_err;
  end
  assign clr   = (acc && pwrite && paddr == slc_pkg::ADDR_EVT_CLEAR) ? pwdata[EVT_W_L-1:0] : '0;
  assign evt_d = (evt_q & ~clr) | ev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= slc_pkg::EVT_RESET;
      irq   <= 1'b0;
    end else begin
      evt_q <= evt_d;
      irq   <= |(evt_d & evt_en_q);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pma_release;
    $fell(rx_pma_s) ##0 !rx_full_s ##1 !rx_pma_s && !rx_full_s;
  endsequence
  a_rx_pcs_holdoff: assert property (rx_pcs_pend_q && !rx_ready_s |=> rx_pcs_pend_q) // [RULE_01]
    else $error("rx pcs reset began without user ready");
  a_rx_pma_start: assert property (s_pma_release |-> ##[1:SEQ_BOUND] rx_pma_reset_done) // [RULE_02]
    else $error("rx pma reset did not complete after release");
  a_rx_pma_low: assert property ((rx_full_s || rx_pma_s) |=> !rx_pma_reset_done) // [RULE_03]
    else $error("pma done high during reset");
  a_err_cnt_clr: assert property (ctrl_q.rx_err_cnt_clear |=> err_cnt_q == '0) // [RULE_04]
    else $error("error counter not cleared");
  a_no_check_off: assert property (!is_prbs(ctrl_q.rx_check_sel) |=> !rx_prbs_err) // [RULE_07]
    else $error("prbs error reported with checking off");
  a_rx_done_ready: assert property (!rx_ready_s || rx_full_s |=> !rx_reset_done) // [RULE_09]
    else $error("rx reset done without ready or during reset");
  a_buf_err_held: assert property (tx_buf_status[1] && !tx_pcs_busy |=> tx_buf_status[1]) // [RULE_10]
    else $error("buffer error bit dropped without reset");
  a_half_full: assert property (##1 tx_buf_status[0] == $past(!tx_pcs_busy && (fill[AW] || fill[AW-1]))) // [RULE_11]
    else $error("half full bit wrong");
  a_inhibit_idle: assert property (ctrl_q.tx_inhibit |=> !serial_out_pos && serial_out_neg) // [RULE_12]
    else $error("inhibit did not idle the line");
  a_pcs_only: assert property (tx_pcs_s && !tx_pma_s && !tx_pma_busy |=> !tx_pma_busy) // [RULE_13]
    else $error("tx pcs reset touched pma");
  a_pma_both: assert property (tx_pma_s |=> tx_pma_busy && tx_pcs_busy) // [RULE_14]
    else $error("tx pma reset did not reset pcs");
  a_polarity: assert property (!ctrl_q.tx_inhibit && !tx_pma_busy && !gen_on
    |=> serial_out_pos == ($past(shift_q[0]) ^ $past(ctrl_q.tx_polarity))) // [RULE_15]
    else $error("serial polarity wrong");
endmodule : slc_lane_ctrl
`default_nettype wire

// ### verification/slc_loop_model.sv
/*
  Serial loopback partner: returns the lane's serial output to its receive input.
  Assumes the single pclk domain; flip inverts every returned bit while it is high.
*/
`timescale 1ns/1ps
`default_nettype none
module slc_loop_model (
  // clock
  input  wire logic pclk,
  // lane side
  input  wire logic line_in,
  input  wire logic flip,
  output logic      line_out
);
  // one flipped bit is enough to provoke the checker's error burst
  always_ff @(posedge pclk) begin
    line_out <= line_in ^ flip;
  end
endmodule : slc_loop_model
`default_nettype wire

// ### verification/testbench.sv
/*
  Self-checking bench of the lane control block: APB tasks, reset pins, loopback.
  Assumes slc_pkg and slc_lane_ctrl compiled first and one 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, rerr, flip;
  logic [7:0]  paddr, tx_parallel_word;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, tx_word_valid, tx_word_ready, pos, neg, irq;
  logic        rx_full_reset, rx_pma_reset, rx_pcs_reset, rx_user_ready;
  logic        tx_pma_reset, tx_pcs_reset, rx_serial_in, rx_prbs_err;
  logic        rx_pma_reset_done, rx_reset_done, tx_reset_done;
  logic [4:0]  main_tap_coef, main_tap_applied;
  logic [1:0]  tx_buf_status;
  slc_pkg::slc_ctrl_s c;
  int          n_errors, check_count;

  slc_lane_ctrl u_slc_lane_ctrl (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_full_reset(rx_full_reset), .rx_pma_reset(rx_pma_reset),
    .rx_pcs_reset(rx_pcs_reset), .rx_user_ready(rx_user_ready),
    .tx_pma_reset(tx_pma_reset), .tx_pcs_reset(tx_pcs_reset),
    .rx_serial_in(rx_serial_in), .main_tap_coef(main_tap_coef),
    .tx_parallel_word(tx_parallel_word), .tx_word_valid(tx_word_valid),
    .tx_word_ready(tx_word_ready), .serial_out_pos(pos), .serial_out_neg(neg),
    .rx_pma_reset_done(rx_pma_reset_done), .rx_reset_done(rx_reset_done),
    .tx_reset_done(tx_reset_done), .rx_prbs_err(rx_prbs_err),
    .tx_buf_status(tx_buf_status), .main_tap_applied(main_tap_applied), .irq(irq));

  slc_loop_model u_slc_loop_model (
    .pclk(pclk), .line_in(pos), .flip(flip), .line_out(rx_serial_in));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // the master never assumes a latency; it waits for pready under a bound
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h1, "pready");
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp, what);
  endtask : rd

  task wctrl;
    apb(1'b1, slc_pkg::ADDR_CTRL, 32'(c));
  endtask : wctrl

  task finish_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial begin
    #200000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, flip} = '0;
    {rx_full_reset, rx_pma_reset, rx_pcs_reset, rx_user_ready} = '0;
    {tx_pma_reset, tx_pcs_reset, tx_word_valid, tx_parallel_word} = '0;
    main_tap_coef = 5'h15;
    c = slc_pkg::CTRL_RESET;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (60) @(posedge pclk);
    chk(tx_reset_done, 1, "tx done");
    chk(rx_pma_reset_done, 1, "pma done");
    chk(rx_reset_done, 0, "rx done early");
    rx_user_ready <= 1'b1;
    repeat (60) @(posedge pclk);
    chk(rx_reset_done, 1, "rx done");
    rd(slc_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
    rd(8'h40, 32'h0, "unmapped data");
    chk(rerr, 1, "unmapped err");
    chk(tx_buf_status[1], 1, "underflow");
    chk({pos, neg}, 2'b01, "plain line");
    c.tx_polarity = 1'b1;
    wctrl();
    repeat (20) @(posedge pclk);
    chk({pos, neg}, 2'b10, "inverted line");
    c.tx_force_err = 1'b1;
    wctrl();
    repeat (20) @(posedge pclk);
    chk({pos, neg}, 2'b10, "force err off");
    c.tx_inhibit = 1'b1;
    wctrl();
    repeat (4) @(posedge pclk);
    chk({pos, neg}, 2'b01, "inhibit");
    c = slc_pkg::CTRL_RESET;
    c.main_tap_direct_enable = 1'b1;
    wctrl();
    repeat (6) @(posedge pclk);
    chk(main_tap_applied, 5'h15, "tap on");
    c = slc_pkg::CTRL_RESET;
    wctrl();
    repeat (6) @(posedge pclk);
    chk(main_tap_applied, 5'h00, "tap off");
    // one word a cycle outruns the serialiser, so the fifo overflows
    tx_word_valid    <= 1'b1;
    tx_parallel_word <= 8'hA5;
    repeat (12) @(posedge pclk);
    chk(tx_buf_status[0], 1, "half full");
    tx_word_valid <= 1'b0;
    repeat (120) @(posedge pclk);
    chk({tx_buf_status[0], tx_word_ready}, 2'b01, "drained");
    rd(slc_pkg::ADDR_EVT_STATUS, 32'h7, "events");
    chk(irq, 0, "irq masked");
    apb(1'b1, slc_pkg::ADDR_EVT_ENABLE, 32'h4);
    repeat (3) @(posedge pclk);
    chk(irq, 1, "irq on");
    for (int p = 1; p <= 4; p++) begin
      c = slc_pkg::CTRL_RESET;
      c.tx_pattern_sel   = 3'(p);
      c.rx_check_sel     = 3'(p);
      c.rx_err_cnt_clear = 1'b1;
      wctrl();
      repeat (80) @(posedge pclk);
      c.rx_err_cnt_clear = 1'b0;
      wctrl();
      repeat (64) @(posedge pclk);
      rd(slc_pkg::ADDR_ERR_CNT, 32'h0, "clean prbs");
      flip <= 1'b1;
      @(posedge pclk);
      flip <= 1'b0;
      repeat (64) @(posedge pclk);
      chk(rx_prbs_err, 0, "err not sticky");
      apb(1'b0, slc_pkg::ADDR_ERR_CNT, 32'h0);
      chk(rdat > 1 && rdat < 64, 1, "burst");
    end
    c.tx_force_err     = 1'b1;
    c.rx_check_sel     = 3'h5;
    c.rx_err_cnt_clear = 1'b1;
    wctrl();
    c.rx_err_cnt_clear = 1'b0;
    wctrl();
    repeat (64) @(posedge pclk);
    rd(slc_pkg::ADDR_ERR_CNT, 32'h0, "no check");
    c.rx_check_sel = 3'h4;
    wctrl();
    repeat (64) @(posedge pclk);
    apb(1'b0, slc_pkg::ADDR_ERR_CNT, 32'h0);
    chk(rdat != 0, 1, "forced errors");
    c.rx_err_cnt_clear = 1'b1;
    wctrl();
    repeat (4) @(posedge pclk);
    rd(slc_pkg::ADDR_ERR_CNT, 32'h0, "count clear");
    c = slc_pkg::CTRL_RESET;
    c.tx_pattern_sel = slc_pkg::PAT_PRBS7;
    wctrl();
    tx_pcs_reset <= 1'b1;
    repeat (6) @(posedge pclk);
    tx_pcs_reset <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(tx_buf_status[1], 0, "buffer reset");
    apb(1'b1, slc_pkg::ADDR_EVT_CLEAR, 32'hF);
    repeat (3) @(posedge pclk);
    chk(irq, 0, "irq cleared");
    tx_pma_reset <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({tx_reset_done, tx_word_ready, pos, neg}, 4'b0001, "tx pma in reset");
    tx_pma_reset <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(tx_reset_done, 1, "tx pma done");
    rx_pma_reset <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(rx_pma_reset_done, 0, "pma busy");
    rx_pma_reset <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(rx_pma_reset_done, 1, "pma again");
    rx_full_reset <= 1'b1;
    rx_user_ready <= 1'b0;
    repeat (6) @(posedge pclk);
    chk({rx_reset_done, rx_pma_reset_done}, 2'b00, "full reset");
    rx_full_reset <= 1'b0;
    repeat (60) @(posedge pclk);
    chk(rx_reset_done, 0, "waits ready");
    rx_user_ready <= 1'b1;
    repeat (60) @(posedge pclk);
    chk(rx_reset_done, 1, "rx ready");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
